// ==== src/emg_gate.sv ====
// Run-state gating of target control inputs and peripheral run enables
//
// Function
// - Target reset reaches processor only in run.
// - Wait and bus request pass only while executing.
// - Bus request mask blocks it during run.
// - Background mode runs loop, bus request starts handler.
// - Watchdog counts only in run or step.
// - Watchdog freezes at break, resumes from value.
// - Pulse and compare timers run always.
// - Serial stays active; transmit write sends data.
// - Free-running counter keeps counting after break.
// - DMA stays active; request performs a transfer.
// - Pulse output on selected pins; 0,1 compare-triggered.
// - Programmable waits apply to both memories.
// - Wait pin sampled only for external memory.
// - Mode setting adds wait pin for emulation memory.
// - Wait pin always sampled in refresh cycles; the code samples it only outside the wait state.
// - Break unit enabled only during emulation.
// - Port pins always active, memory commands reach them.
// - Trigger probe emits one low pulse.
// - Basic bus cycle takes two states.
// - Background loop must sit in internal RAM.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module emg_gate (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TGT_RESET_N,
  input wire logic TGT_WAIT_N,
  input wire logic TGT_BUS_REQUEST_INPUT_N,
  input wire logic DMA_REQ,
  input wire logic [7:0] PORT_IN,
  input wire logic BRK_IN,
  input wire logic ACC_REQ,
  input wire logic ACC_EMU,
  input wire logic ACC_REFRESH,
  input wire logic CMP2_MATCH,
  input wire logic [5:0] PULSE_TRIG,
  output logic CPU_RESET_N,
  output logic CPU_WAIT_N,
  output logic CPU_BUS_REQUEST_INPUT_N,
  output logic BG_LOOP,
  output logic BG_IRQ,
  output logic WDT_RUN,
  output logic UBC_EN,
  output logic [4:0] PERIPH_EN,
  output logic DMA_GO,
  output logic [7:0] TX_DATA,
  output logic TX_LOAD,
  output logic [7:0] PORT_OUT,
  output logic [7:0] PULSE_OUT,
  output logic TRIG_N,
  output logic ACC_DONE
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  emg_pkg::emg_pins_t pin_raw; // Pins, inverted to active high
  emg_pkg::emg_pins_t ps; // Pins after synchroniser

  assign pin_raw = '{port: PORT_IN, dreq: DMA_REQ, bus_request_input: ~TGT_BUS_REQUEST_INPUT_N,
                     wt: ~TGT_WAIT_N, rst: ~TGT_RESET_N};

  // Every target pin is asynchronous to CLOCK
  emg_sync #(
    .W(12)
  ) u_sync (
    .CLOCK(CLOCK),
    .RSTN(RSTN),
    .D(pin_raw),
    .Q(ps)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State and decoded strobes

  emg_pkg::emg_regs_t q; // Registered state
  emg_pkg::emg_regs_t n; // Next state

  logic setup; // APB setup phase
  logic wr; // APB write completes this edge
  logic [emg_pkg::CMD_W-1:0] cmd; // Command strobes
  logic executing; // Any execution state
  logic user_run; // User program running
  logic bg_ok; // Background loop lies in internal RAM
  logic w_gate; // Wait pin accepted this cycle
  logic [7:0] trig_vec; // Pulse trigger per pin

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    n = q;
    setup = PSEL & ~PENABLE;
    wr = PSEL & PENABLE & PWRITE & q.pready;
    cmd = (wr && (PADDR == emg_pkg::OFF_CMD)) ? PWDATA[emg_pkg::CMD_W-1:0] : '0;
    executing = (q.st != emg_pkg::ST_WAIT);
    user_run = (q.st == emg_pkg::ST_RUN) || (q.st == emg_pkg::ST_STEP);
    // Loop outside internal RAM is refused, not run
    bg_ok = (q.bgadr >= emg_pkg::IRAM_BASE) && (q.bgadr <= emg_pkg::IRAM_TOP);
    // Refresh looks at the pin in any execution state; emulation memory only when enabled
    w_gate = executing && ps.wt && (ACC_REFRESH ||
             (q.busy && (!ACC_EMU || q.mode[emg_pkg::MODE_WAIT_EMU])));
    trig_vec = {PULSE_TRIG, CMP2_MATCH, CMP2_MATCH};

    // Single-cycle pulses default low
    n.tx_load = 1'b0;
    n.bg_irq = 1'b0;
    n.dma_go = 1'b0;
    n.acc_done = 1'b0;

    // APB: answer in the first access cycle, no wait states
    n.pready = setup;
    if (setup) begin
      n.pslverr = 1'b0;
      case (PADDR)
        emg_pkg::OFF_CMD: n.prdata = '0;
        emg_pkg::OFF_MODE: n.prdata = {28'h0000000, q.mode};
        emg_pkg::OFF_STAT: n.prdata = {24'h000000, ~q.trig_n, q.busy, bg_ok, q.run, q.st};
        emg_pkg::OFF_WDT: n.prdata = {16'h0000, q.wdt};
        emg_pkg::OFF_BGADR: n.prdata = q.bgadr;
        emg_pkg::OFF_WS: n.prdata = {28'h0000000, q.ws};
        emg_pkg::OFF_PSEL: n.prdata = {24'h000000, q.psel};
        emg_pkg::OFF_TX: n.prdata = {24'h000000, q.tx_data};
        emg_pkg::OFF_PORT: n.prdata = {16'h0000, ps.port, q.port_out};
        default: begin
          // Unmapped: read zero and flag the error
          n.prdata = '0;
          n.pslverr = 1'b1;
        end
      endcase
    end

    // APB writes take effect at the completing edge only
    if (wr) begin
      case (PADDR)
        emg_pkg::OFF_MODE: n.mode = PWDATA[3:0];
        emg_pkg::OFF_BGADR: n.bgadr = PWDATA;
        emg_pkg::OFF_WS: n.ws = PWDATA[3:0];
        emg_pkg::OFF_PSEL: n.psel = PWDATA[7:0];
        emg_pkg::OFF_PORT: n.port_out = PWDATA[7:0];
        emg_pkg::OFF_TX: begin
          // Only a prepared interface ships the byte
          if (q.mode[emg_pkg::MODE_TX_READY]) begin
            n.tx_data = PWDATA[7:0];
            n.tx_load = 1'b1;
          end
        end
        default: begin
          // Other offsets store nothing here; the watchdog offset is loaded further down
        end
      endcase
    end

    // Sequencer; commands outside their state are ignored
    unique case (q.st)
      emg_pkg::ST_WAIT: begin
        if (cmd[emg_pkg::CMD_GO]) begin
          n.st = emg_pkg::ST_RUN;
          n.run = 1'b1;
        end else if (cmd[emg_pkg::CMD_STEP] || cmd[emg_pkg::CMD_STOV]) begin
          n.st = emg_pkg::ST_STEP;
          n.run = 1'b1;
        end else if (cmd[emg_pkg::CMD_MEM]) begin
          n.st = emg_pkg::ST_MEM;
        end
      end
      emg_pkg::ST_RUN, emg_pkg::ST_STEP: begin
        // Break from the break logic or from software
        if (BRK_IN || cmd[emg_pkg::CMD_BRK]) begin
          n.st = emg_pkg::ST_WAIT;
          n.run = 1'b0;
        end
      end
      emg_pkg::ST_MEM: begin
        if (cmd[emg_pkg::CMD_MEMEND]) begin
          n.st = emg_pkg::ST_WAIT;
        end
      end
    endcase

    // Target reset only reaches the core during a run started by go
    n.cpu_rst_n = !((q.st == emg_pkg::ST_RUN) && ps.rst);

    // Bus request in any execution state, masked during user run
    n.cpu_bus_request_input_n = !(ps.bus_request_input && executing &&
                     !(user_run && q.mode[emg_pkg::MODE_BUS_REQUEST_INPUT_MASK]));
    n.cpu_wait_n = !w_gate;

    // Background loop while waiting; new request starts its handler
    n.bg_loop = (q.st == emg_pkg::ST_WAIT) && q.mode[emg_pkg::MODE_BG_INT] && bg_ok;
    n.bus_request_input_d = ps.bus_request_input;
    n.bg_irq = q.bg_loop && ps.bus_request_input && !q.bus_request_input_d;

    // Watchdog counts under the run flag only, keeping its value otherwise
    if (wr && (PADDR == emg_pkg::OFF_WDT)) begin
      n.wdt = PWDATA[15:0];
    end else if (q.run) begin
      n.wdt = q.wdt + 16'h0001;
    end

    // Break unit follows the run flag
    n.ubc_en = q.run;

    // Timers, serial, dma and ports never stop with the sequencer
    n.periph_en = emg_pkg::PERIPH_ALL;

    // Each new transfer request is served in every state
    n.dreq_d = ps.dreq;
    n.dma_go = ps.dreq && !q.dreq_d;

    // Pulse output on selected pins
    n.pulse = q.psel & trig_vec;

    // Trigger probe: one low pulse, a repeat request is ignored meanwhile
    if (q.trig_cnt != 4'h0) begin
      n.trig_cnt = q.trig_cnt - 4'h1;
    end else if (cmd[emg_pkg::CMD_TRIG]) begin
      n.trig_cnt = emg_pkg::TRIG_CYC;
    end
    n.trig_n = (n.trig_cnt == 4'h0);

    // Bus cycle: two base states plus programmed waits, then wait pin
    if (!q.busy) begin
      if (ACC_REQ) begin
        n.busy = 1'b1;
        n.acc_cnt = emg_pkg::BUS_BASE_STATES - 5'h01 + {1'b0, q.ws};
      end
    end else if (q.acc_cnt != 5'h00) begin
      n.acc_cnt = q.acc_cnt - 5'h01;
    end else if (!w_gate) begin
      n.busy = 1'b0;
      n.acc_done = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset; all outputs come from here
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      q <= emg_pkg::REGS_RST;
    end else begin
      q <= n;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign CPU_RESET_N = q.cpu_rst_n;
  assign CPU_WAIT_N = q.cpu_wait_n;
  assign CPU_BUS_REQUEST_INPUT_N = q.cpu_bus_request_input_n;
  assign BG_LOOP = q.bg_loop;
  assign BG_IRQ = q.bg_irq;
  assign WDT_RUN = q.run;
  assign UBC_EN = q.ubc_en;
  assign PERIPH_EN = q.periph_en;
  assign DMA_GO = q.dma_go;
  assign TX_DATA = q.tx_data;
  assign TX_LOAD = q.tx_load;
  assign PORT_OUT = q.port_out;
  assign PULSE_OUT = q.pulse;
  assign TRIG_N = q.trig_n;
  assign ACC_DONE = q.acc_done;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  property p_rst_gate;
    (q.st != emg_pkg::ST_RUN) |=> CPU_RESET_N;
  endproperty
  a_rst_gate: assert property (p_rst_gate) else $error("target reset leaked");

  property p_wait_block;
    (q.st == emg_pkg::ST_WAIT) |=> (CPU_WAIT_N && CPU_BUS_REQUEST_INPUT_N);
  endproperty
  a_wait_block: assert property (p_wait_block) else $error("pin passed in wait");

  property p_bus_request_input_mask;
    (user_run && q.mode[emg_pkg::MODE_BUS_REQUEST_INPUT_MASK]) |=> CPU_BUS_REQUEST_INPUT_N;
  endproperty
  a_bus_request_input_mask: assert property (p_bus_request_input_mask) else $error("masked request passed");

  property p_mem_bus_request_input;
    (q.st == emg_pkg::ST_MEM && ps.bus_request_input) |=> (!CPU_BUS_REQUEST_INPUT_N && CPU_RESET_N);
  endproperty
  a_mem_bus_request_input: assert property (p_mem_bus_request_input) else $error("memory state gating");

  property p_bg_irq;
    (BG_LOOP && ps.bus_request_input && !q.bus_request_input_d) |=> BG_IRQ;
  endproperty
  a_bg_irq: assert property (p_bg_irq) else $error("handler not started");

  property p_wdt_hold;
    (!q.run && !(wr && PADDR == emg_pkg::OFF_WDT)) |=> $stable(q.wdt);
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog moved when held");

  property p_wdt_count;
    (q.run && !(wr && PADDR == emg_pkg::OFF_WDT)) |=> (q.wdt == $past(q.wdt) + 16'h0001);
  endproperty
  a_wdt_count: assert property (p_wdt_count) else $error("watchdog did not count");

  property p_ubc;
    q.run |=> UBC_EN;
  endproperty
  a_ubc: assert property (p_ubc) else $error("break unit off in run");

  property p_refresh;
    (executing && ps.wt && ACC_REFRESH) |=> !CPU_WAIT_N;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh wait missed");

  sequence s_take;
    ACC_REQ && !q.busy;
  endsequence
  sequence s_two_states;
    q.busy && !ACC_DONE ##1 q.busy && !ACC_DONE;
  endsequence
  property p_bus_cycle;
    s_take |=> s_two_states;
  endproperty
  a_bus_cycle: assert property (p_bus_cycle) else $error("bus cycle too short");

  sequence s_trig_go;
    cmd[emg_pkg::CMD_TRIG] && q.trig_cnt == 4'h0;
  endsequence
  property p_trig;
    s_trig_go |=> !TRIG_N [*8] ##1 !TRIG_N ##1 !TRIG_N ##1 TRIG_N;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger pulse width");

  property p_tx;
    (wr && PADDR == emg_pkg::OFF_TX && q.mode[emg_pkg::MODE_TX_READY])
      |=> (TX_LOAD && TX_DATA == $past(PWDATA[7:0]));
  endproperty
  a_tx: assert property (p_tx) else $error("transmit write lost");

endmodule

// ==== src/emg_pkg.sv ====
// Shared constants, state codes and carriers of the run-state gating block
package emg_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_WDT = 8'h0C;
  localparam logic [7:0] OFF_BGADR = 8'h10;
  localparam logic [7:0] OFF_WS = 8'h14;
  localparam logic [7:0] OFF_PSEL = 8'h18;
  localparam logic [7:0] OFF_TX = 8'h1C;
  localparam logic [7:0] OFF_PORT = 8'h20;

  // Command register bit positions (write one to act)
  localparam int CMD_GO = 0;
  localparam int CMD_STEP = 1;
  localparam int CMD_STOV = 2;
  localparam int CMD_MEM = 3;
  localparam int CMD_MEMEND = 4;
  localparam int CMD_BRK = 5;
  localparam int CMD_TRIG = 6;
  localparam int CMD_W = 7;

  // Execution mode register bit positions
  localparam int MODE_BUS_REQUEST_INPUT_MASK = 0;
  localparam int MODE_WAIT_EMU = 1;
  localparam int MODE_BG_INT = 2;
  localparam int MODE_TX_READY = 3;

  // Internal RAM window that may hold the background loop
  localparam logic [31:0] IRAM_BASE = 32'h0000_F000;
  localparam logic [31:0] IRAM_TOP = 32'h0000_FFFF;

  // Bus cycle length in bus clock states
  localparam logic [4:0] BUS_BASE_STATES = 5'h02;

  // Trigger probe pulse width, least time, rounded up to cycles
  localparam int CLK_MHZ = 125;
  localparam int TRIG_NS = 80;
  localparam logic [3:0] TRIG_CYC = 4'((TRIG_NS * CLK_MHZ + 999) / 1000);

  // Peripherals that stay alive in every state: timers, serial, dma, ports
  localparam logic [4:0] PERIPH_ALL = 5'h1F;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_WAIT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_STEP = 4'b0100,
    ST_MEM = 4'b1000
  } emg_state_t;

  // Synchronised target pins, all active high after inversion
  typedef struct packed {
    logic [7:0] port;
    logic dreq;
    logic bus_request_input;
    logic wt;
    logic rst;
  } emg_pins_t;

  // Whole state of the gating block
  typedef struct packed {
    emg_state_t st;
    logic run;
    logic [3:0] mode;
    logic [3:0] ws;
    logic [31:0] bgadr;
    logic [7:0] psel;
    logic [15:0] wdt;
    logic [7:0] port_out;
    logic [7:0] tx_data;
    logic tx_load;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_rst_n;
    logic cpu_wait_n;
    logic cpu_bus_request_input_n;
    logic bg_loop;
    logic bg_irq;
    logic bus_request_input_d;
    logic ubc_en;
    logic [4:0] periph_en;
    logic dreq_d;
    logic dma_go;
    logic [7:0] pulse;
    logic [3:0] trig_cnt;
    logic trig_n;
    logic busy;
    logic [4:0] acc_cnt;
    logic acc_done;
  } emg_regs_t;

  // Value after reset
  localparam emg_regs_t REGS_RST = '{
    st: ST_WAIT,
    cpu_rst_n: 1'b1,
    cpu_wait_n: 1'b1,
    cpu_bus_request_input_n: 1'b1,
    trig_n: 1'b1,
    periph_en: PERIPH_ALL,
    default: '0
  };

endpackage

// ==== src/emg_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module emg_sync #(
  parameter int W = 1
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);

  // All stages travel together
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } emg_sync_st_t;

  emg_sync_st_t q_r;
  emg_sync_st_t next_q;

  // Stage one feeds stage two only; agreement filters a single-cycle glitch
  always_comb begin
    next_q = q_r;
    next_q.s1 = D;
    next_q.s2 = q_r.s1;
    next_q.s3 = q_r.s2;
    next_q.q = (q_r.s2 & q_r.s3) | (q_r.q & (q_r.s2 | q_r.s3));
  end

  // Synchronous reset to the idle level
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      q_r <= '0;
    end else begin
      q_r <= next_q;
    end
  end

  assign Q = q_r.q;

endmodule

// ==== bench/emg_tgt_model.sv ====
// Behavioural user target system that drives the emulator's control pins
`timescale 1ns/100ps
module emg_tgt_model (
  input wire logic CLOCK,
  input wire logic rst_on,
  input wire logic bus_request_input_on,
  input wire logic dma_on,
  input wire logic [7:0] port_val,
  input wire logic [4:0] wait_len,
  input wire logic wait_go,
  output logic TGT_RESET_N,
  output logic TGT_WAIT_N,
  output logic TGT_BUS_REQUEST_INPUT_N,
  output logic DMA_REQ,
  output logic [7:0] PORT_IN
);
  logic [4:0] wcnt; // Cycles left of a slow wait answer

  // Idle target: nothing requested at time zero
  initial begin
    wcnt = 5'h00;
    {TGT_RESET_N, TGT_BUS_REQUEST_INPUT_N, DMA_REQ, PORT_IN} = {1'b1, 1'b1, 1'b0, 8'h00};
  end

  // Pins move just after an edge, as synchronous target logic would
  always @(posedge CLOCK) begin
    TGT_RESET_N <= ~rst_on;
    TGT_BUS_REQUEST_INPUT_N <= ~bus_request_input_on;
    DMA_REQ <= dma_on;
    PORT_IN <= port_val;
    // Long waits model a slow memory; zero length answers at once
    wcnt <= wait_go ? wait_len : ((wcnt != 5'h00) ? wcnt - 5'h01 : 5'h00);
  end

  assign TGT_WAIT_N = (wcnt == 5'h00);
endmodule

// ==== bench/tb_emulator_run_state_gating.sv ====
// Self-checking bench of the run-state gating block
`timescale 1ns/100ps
module tb_emulator_run_state_gating;
  logic clk, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, brk = 1'b0;
  logic acc = 1'b0, acc_emu = 1'b0, acc_ref = 1'b0, cmp2 = 1'b0, wgo = 1'b0;
  logic rst_on = 1'b0, bus_request_input_on = 1'b0, dma_on = 1'b0;
  logic [7:0] paddr = 8'h00, pval = 8'h00;
  logic [5:0] ptrig = 6'h00;
  logic [4:0] wlen = 5'h00;
  logic [31:0] pwdata = 32'h0, rnd = 32'h60A7, rd, w1, w2, ws;
  logic [31:0] prdata;
  logic pready, pslverr, err, trst_n, twait_n, tbreq_n, tdma;
  logic cpu_rst_n, cpu_wait_n, cpu_bus_request_input_n, bg_loop, bg_irq, wdt_run, ubc_en;
  logic dma_go, tx_load, trig_n, acc_done;
  logic [4:0] periph_en;
  logic [7:0] tport, tx_data, port_out, pulse_out;
  int bad_count, check_count, cyc, irq_n, dma_n, txl_n, trig_lo, n, wlo_n;

  emg_gate u_dut (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TGT_RESET_N(trst_n), .TGT_WAIT_N(twait_n), .TGT_BUS_REQUEST_INPUT_N(tbreq_n),
    .DMA_REQ(tdma), .PORT_IN(tport), .BRK_IN(brk), .ACC_REQ(acc), .ACC_EMU(acc_emu),
    .ACC_REFRESH(acc_ref), .CMP2_MATCH(cmp2), .PULSE_TRIG(ptrig), .CPU_RESET_N(cpu_rst_n),
    .CPU_WAIT_N(cpu_wait_n), .CPU_BUS_REQUEST_INPUT_N(cpu_bus_request_input_n), .BG_LOOP(bg_loop), .BG_IRQ(bg_irq),
    .WDT_RUN(wdt_run), .UBC_EN(ubc_en), .PERIPH_EN(periph_en), .DMA_GO(dma_go),
    .TX_DATA(tx_data), .TX_LOAD(tx_load), .PORT_OUT(port_out), .PULSE_OUT(pulse_out),
    .TRIG_N(trig_n), .ACC_DONE(acc_done));

  emg_tgt_model u_tgt (.CLOCK(clk), .rst_on(rst_on), .bus_request_input_on(bus_request_input_on), .dma_on(dma_on),
    .port_val(pval), .wait_len(wlen), .wait_go(wgo), .TGT_RESET_N(trst_n),
    .TGT_WAIT_N(twait_n), .TGT_BUS_REQUEST_INPUT_N(tbreq_n), .DMA_REQ(tdma), .PORT_IN(tport));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pulse counters and the hang limit; counting beats catching a one-cycle pulse by hand
  always @(posedge clk) begin
    irq_n <= irq_n + int'(bg_irq === 1'b1);
    dma_n <= dma_n + int'(dma_go === 1'b1);
    txl_n <= txl_n + int'(tx_load === 1'b1);
    trig_lo <= trig_lo + int'(trig_n === 1'b0);
    wlo_n <= wlo_n + int'(cpu_wait_n === 1'b0);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next pseudo-random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write one command bit
  task automatic cmd(input int b);
    apb(1'b1, emg_pkg::OFF_CMD, 32'h1 << b);
  endtask

  // Bus access with an optional slow wait from the target; n is edges to done
  task automatic access(input logic emu, input logic rf, input logic [4:0] wl);
    @(posedge clk);
    wlen <= wl;
    wgo <= (wl != 5'h00);
    @(posedge clk);
    wgo <= 1'b0;
    repeat (6) @(posedge clk);
    acc <= 1'b1;
    acc_emu <= emu;
    acc_ref <= rf;
    @(posedge clk);
    acc <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (acc_done !== 1'b1 && n < 60);
    repeat (int'(wl) + 6) @(posedge clk);
  endtask

  // Access under a mode setting; stretched ones must outlast the programmed length
  task automatic acc_chk(input logic w, emu, rf, m1, ext);
    int w0;
    apb(1'b1, emg_pkg::OFF_MODE, {28'h0, 1'b0, 1'b0, m1, 1'b0});
    w0 = wlo_n;
    access(emu, rf, w ? 5'h14 : 5'h00);
    if (ext) chk(n > 2 + ws + 4, 1, "access not stretched");
    else chk(n, 2 + ws, "access length");
    chk(wlo_n != w0, ext, "wait pin gating");
  endtask

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; reset held three edges, which clears every synchroniser stage
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, emg_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h1, "state after reset");
    chk({cpu_rst_n, cpu_wait_n, cpu_bus_request_input_n, trig_n}, 4'hF, "reset outputs");
    apb(1'b0, 8'h24, 32'h0);
    chk({err, rd[0]}, 2'b10, "unmapped read");
    $display("test done: reset");
    // Target pins blocked in wait, request only in memory state, all in run
    rst_on <= 1'b1;
    bus_request_input_on <= 1'b1;
    repeat (8) @(posedge clk);
    chk({cpu_rst_n, cpu_bus_request_input_n}, 2'b11, "pins leak in wait");
    cmd(emg_pkg::CMD_MEM);
    repeat (8) @(posedge clk);
    chk({cpu_rst_n, cpu_bus_request_input_n}, 2'b10, "memory state gating");
    cmd(emg_pkg::CMD_MEMEND);
    cmd(emg_pkg::CMD_GO);
    repeat (8) @(posedge clk);
    chk({cpu_rst_n, cpu_bus_request_input_n, ubc_en, wdt_run}, 4'b0011, "run gating");
    chk(periph_en, emg_pkg::PERIPH_ALL, "peripherals in run");
    apb(1'b1, emg_pkg::OFF_MODE, 32'h1);
    repeat (8) @(posedge clk);
    chk(cpu_bus_request_input_n, 1'b1, "masked request");
    rst_on <= 1'b0;
    bus_request_input_on <= 1'b0;
    cmd(emg_pkg::CMD_BRK);
    repeat (8) @(posedge clk);
    chk({cpu_rst_n, cpu_bus_request_input_n, ubc_en, wdt_run}, 4'b1100, "after break");
    chk(periph_en, emg_pkg::PERIPH_ALL, "peripherals in wait");
    $display("test done: gating");
    // Watchdog holds in wait, counts in step, freezes at break, resumes in run
    rnd = lfsr(rnd);
    w1 = {24'h0, rnd[7:0]};
    apb(1'b1, emg_pkg::OFF_WDT, w1);
    repeat (20) @(posedge clk);
    apb(1'b0, emg_pkg::OFF_WDT, 32'h0);
    chk(rd, w1, "count in wait");
    cmd(emg_pkg::CMD_STEP);
    repeat (30) @(posedge clk);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    apb(1'b0, emg_pkg::OFF_WDT, 32'h0);
    w2 = rd;
    chk(w2 >= w1 + 30, 1, "count in step");
    repeat (20) @(posedge clk);
    apb(1'b0, emg_pkg::OFF_WDT, 32'h0);
    chk(rd, w2, "frozen at break");
    cmd(emg_pkg::CMD_GO);
    repeat (20) @(posedge clk);
    cmd(emg_pkg::CMD_BRK);
    apb(1'b0, emg_pkg::OFF_WDT, 32'h0);
    chk(rd >= w2 + 20, 1, "resume from held value");
    cmd(emg_pkg::CMD_STOV);
    apb(1'b0, emg_pkg::OFF_STAT, 32'h0);
    chk(rd, 32'h14, "step-over starts step");
    cmd(emg_pkg::CMD_BRK);
    $display("test done: watchdog");
    // Background loop only from internal RAM; request starts one handler
    rnd = lfsr(rnd);
    apb(1'b1, emg_pkg::OFF_BGADR, emg_pkg::IRAM_BASE + {20'h0, rnd[11:0]});
    apb(1'b1, emg_pkg::OFF_MODE, 32'h4);
    repeat (3) @(posedge clk);
    chk(bg_loop, 1'b1, "loop in wait");
    w1 = irq_n;
    bus_request_input_on <= 1'b1;
    repeat (10) @(posedge clk);
    chk(irq_n - w1, 1, "handler start");
    chk(cpu_bus_request_input_n, 1'b1, "request leaks in wait");
    bus_request_input_on <= 1'b0;
    apb(1'b1, emg_pkg::OFF_BGADR, emg_pkg::IRAM_TOP + 32'h1);
    repeat (3) @(posedge clk);
    chk(bg_loop, 1'b0, "loop outside ram");
    $display("test done: background");
    // Transmit refused until prepared; dma, ports and pulses live in wait
    rnd = lfsr(rnd);
    w1 = txl_n;
    apb(1'b1, emg_pkg::OFF_MODE, 32'h0);
    apb(1'b1, emg_pkg::OFF_TX, rnd);
    repeat (3) @(posedge clk);
    chk(txl_n - w1, 0, "send while not ready");
    apb(1'b1, emg_pkg::OFF_MODE, 32'h8);
    apb(1'b1, emg_pkg::OFF_TX, {24'h0, rnd[15:8]});
    repeat (3) @(posedge clk);
    chk(tx_data, rnd[15:8], "sent data");
    chk(txl_n - w1, 1, "one load");
    w1 = dma_n;
    dma_on <= 1'b1;
    repeat (8) @(posedge clk);
    dma_on <= 1'b0;
    repeat (8) @(posedge clk);
    chk(dma_n - w1, 1, "dma in wait");
    pval <= rnd[23:16];
    apb(1'b1, emg_pkg::OFF_PORT, {24'h0, rnd[7:0]});
    repeat (6) @(posedge clk);
    apb(1'b0, emg_pkg::OFF_PORT, 32'h0);
    chk(rd, {16'h0, rnd[23:16], rnd[7:0]}, "port read");
    chk(port_out, rnd[7:0], "port out");
    w2 = {24'h0, rnd[31:24] | 8'h03};
    apb(1'b1, emg_pkg::OFF_PSEL, w2);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      cmp2 <= rnd[8];
      ptrig <= rnd[14:9];
      @(posedge clk);
      cmp2 <= 1'b0;
      ptrig <= 6'h00;
      #1;
      chk(pulse_out, w2[7:0] & {rnd[14:8], rnd[8]}, "pulse pins");
    end
    w1 = trig_lo;
    cmd(emg_pkg::CMD_TRIG);
    cmd(emg_pkg::CMD_TRIG);
    repeat (20) @(posedge clk);
    chk(trig_lo - w1, emg_pkg::TRIG_CYC, "trigger width");
    $display("test done: peripherals");
    // Bus cycles: basic length, then random programmed waits
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      ws = (k == 0) ? 32'h0 : {30'h0, rnd[1:0]};
      apb(1'b1, emg_pkg::OFF_WS, ws);
      acc_chk(1, 0, 1, 0, 0);
      cmd(emg_pkg::CMD_MEM);
      acc_chk(0, 0, 0, 0, 0);
      acc_chk(0, 1, 0, 0, 0);
      acc_chk(1, 0, 0, 0, 1);
      acc_chk(1, 1, 0, 0, 0);
      acc_chk(1, 1, 0, 1, 1);
      acc_chk(1, 1, 1, 0, 1);
      cmd(emg_pkg::CMD_MEMEND);
    end
    $display("test done: bus cycles");
    wrap_up();
  end
endmodule
